//--- cell_fault_timer_logic_tb_top.sv
`timescale 1ns/1ps
module cell_fault_timer_logic_tb_top;
  import cft_pkg::*;
  localparam int TDIV = 1000;
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  cft_cmp_t    cmpIn = '0;
  cft_cfg_t    cfgIn = '0;
  logic [3:0]  regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0;
  logic        regWe = 1'b0;
  logic        regRe = 1'b0;
  logic [15:0] regRdata;
  logic        chargeGateOut;
  logic        dischargeGateOut;
  cft_cfg_t    refSel;
  logic        chargeOn;
  logic        dischargeOn;
  logic [15:0] rd;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          recTicks = 16;

  always #4 mclk = ~mclk;

  cft_fault_timer #(.TICK_CYCLES(1), .TIME_DIV(TDIV)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .cmpIn(cmpIn), .cfgIn(cfgIn),
    .regAddr(regAddr), .regWdata(regWdata), .regWe(regWe), .regRe(regRe),
    .regRdata(regRdata), .chargeGateOut(chargeGateOut),
    .dischargeGateOut(dischargeGateOut), .refSel(refSel));

  cft_fet_model fets (.chargeGate(chargeGateOut),
    .dischargeGate(dischargeGateOut), .chargeOn(chargeOn),
    .dischargeOn(dischargeOn));

  function automatic logic gate(input int f, input logic own);
    return ((f == F_OVC || f == F_OCC) == own) ? chargeOn : dischargeOn;
  endfunction

  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // bounded wait: a gate that never moves ends the run
  task automatic wait_gate(input int f, input logic v, input int bound);
    int n;
    n = 0;
    while (gate(f, 1'b1) !== v && n < bound) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("gate", {15'h0, v}, {15'h0, gate(f, 1'b1)});
    if (gate(f, 1'b1) !== v) end_of_test();
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge mclk);
    regWe <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge mclk);
    regRe <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic do_reset(input logic [1:0] d);
    @(posedge mclk);
    sys_rst <= 1'b1;
    cmpIn <= '0;
    cfgIn <= '{ovcDly: d, uvdDly: d, ocdDly: d, occDly: d, ovcThr: 4'h3,
      uvdThr: 5'h04, ocdThr: 5'h1f, occThr: 5'h05, shortThr: 2'h2};
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    recTicks = 16;
    repeat (3) @(posedge mclk);
    #1 chk("ocdThr", {11'h0, OCD_THR_MAX}, {11'h0, refSel.ocdThr});
    chk("gates", 16'h3, {14'h0, chargeOn, dischargeOn});
    @(posedge mclk);
    cfgIn <= ~cfgIn;
    reg_read(REG_RECOVERY, rd);
    chk("recovery", 16'h0010, rd);
    reg_write(REG_CONFIG, 16'hffff);
    reg_read(REG_CONFIG, rd);
    chk("config", {8'h0, d, d, d, d}, rd);
  endtask

  task automatic trip(input int f, input int lim, input logic [3:0] rel,
                      input logic [3:0] part);
    @(posedge mclk);
    cmpIn.detect[f] <= 1'b1;
    cmpIn[3:0] <= 4'h0;
    if (lim > 2) begin
      repeat (lim - 2) @(posedge mclk);
      #1 chk("early gate", 16'h1, {15'h0, gate(f, 1'b1)});
    end
    wait_gate(f, 1'b0, 8);
    chk("other gate", 16'h1, {15'h0, gate(f, 1'b0)});
    reg_read(REG_STATUS, rd);
    chk("status", 16'h1, {15'h0, rd[f]});
    @(posedge mclk);
    cmpIn.detect[f] <= 1'b0;
    cmpIn[3:0] <= part;
    if (part != 4'h0) begin
      repeat (recTicks + 6) @(posedge mclk);
      #1 chk("held gate", 16'h0, {15'h0, gate(f, 1'b1)});
    end
    @(posedge mclk);
    cmpIn[3:0] <= rel;
    wait_gate(f, 1'b1, recTicks + 10);
  endtask

  task automatic run_delays(input int i);
    do_reset(i[1:0]);
    trip(F_OVC, OVC_DLY_US[i] / TDIV, 4'hc, 4'h8);
    trip(F_UVD, UVD_DLY_US[i] / TDIV, 4'h2, 4'h0);
    trip(F_OCD, OCD_DLY_US[i] / TDIV, 4'h1, 4'h0);
    trip(F_OCC, OCC_DLY_US[i] / TDIV, 4'h4, 4'h0);
  endtask

  // a fault returning inside the recovery window must restart the wait
  task automatic recur_check();
    reg_write(REG_RECOVERY, 16'h0014);
    reg_read(REG_RECOVERY, rd);
    chk("recovery", 16'h0014, rd);
    recTicks = 20;
    @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b1;
    cmpIn[3:0] <= 4'h0;
    wait_gate(F_OCD, 1'b0, 20);
    @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b0;
    cmpIn[3:0] <= 4'h1;
    repeat (8) @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b1;
    repeat (2) @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b0;
    repeat (16) @(posedge mclk);
    #1 chk("recurred gate", 16'h0, {15'h0, dischargeOn});
    wait_gate(F_OCD, 1'b1, 30);
  endtask

  // leftover qualification count would make the following trip fire early
  task automatic early_clear();
    @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b1;
    repeat (5) @(posedge mclk);
    cmpIn.detect[F_OCD] <= 1'b0;
    repeat (12) @(posedge mclk);
    #1 chk("pulse gate", 16'h1, {15'h0, dischargeOn});
    trip(F_OCD, OCD_DLY_US[0] / TDIV, 4'h1, 4'h0);
  endtask

  initial begin
    for (int i = 3; i >= 0; i--) run_delays(i);
    chk("frozen cfg", 16'h0, {14'h0, refSel.ocdDly});
    trip(F_SHORT, 1, 4'h1, 4'h0);
    reg_read(REG_EVENT, rd);
    chk("events", 16'h001f, rd);
    reg_write(REG_EVENT, 16'h001f);
    reg_read(REG_EVENT, rd);
    chk("events cleared", 16'h0, rd);
    reg_read(4'hf, rd);
    chk("unmapped", 16'h0, rd);
    recur_check();
    early_clear();
    end_of_test();
  end
endmodule

//--- cft_fault_timer.sv
`timescale 1ns/1ps
module cft_fault_timer #(
  parameter int TICK_CYCLES = cft_pkg::CLK_MHZ * cft_pkg::TICK_US,
  parameter int TIME_DIV    = 1
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire cft_pkg::cft_cmp_t cmpIn,
  input  wire cft_pkg::cft_cfg_t cfgIn,
  input  wire logic [3:0]       regAddr,
  input  wire logic [15:0]      regWdata,
  input  wire logic             regWe,
  input  wire logic             regRe,
  output logic      [15:0]      regRdata,
  output logic                  chargeGateOut,
  output logic                  dischargeGateOut,
  output cft_pkg::cft_cfg_t     refSel
);
  import cft_pkg::*;

  // delays are scaled by TIME_DIV so a simulation can shrink them
  function automatic logic [22:0] dlyTicks(input int us);
    int q;
    q = us / (TICK_US * TIME_DIV);
    if (q < 1) begin
      q = 1;
    end
    return q[22:0];
  endfunction

  localparam logic [22:0] OVC_LIM [4] = '{dlyTicks(OVC_DLY_US[0]),
    dlyTicks(OVC_DLY_US[1]), dlyTicks(OVC_DLY_US[2]),
    dlyTicks(OVC_DLY_US[3])};
  localparam logic [22:0] UVD_LIM [4] = '{dlyTicks(UVD_DLY_US[0]),
    dlyTicks(UVD_DLY_US[1]), dlyTicks(UVD_DLY_US[2]),
    dlyTicks(UVD_DLY_US[3])};
  localparam logic [22:0] OCD_LIM [4] = '{dlyTicks(OCD_DLY_US[0]),
    dlyTicks(OCD_DLY_US[1]), dlyTicks(OCD_DLY_US[2]),
    dlyTicks(OCD_DLY_US[3])};
  localparam logic [22:0] OCC_LIM [4] = '{dlyTicks(OCC_DLY_US[0]),
    dlyTicks(OCC_DLY_US[1]), dlyTicks(OCC_DLY_US[2]),
    dlyTicks(OCC_DLY_US[3])};
  localparam logic [22:0] SHORT_LIM = dlyTicks(SHORT_DLY_US);
  localparam logic [7:0]  TICK_LAST = 8'(TICK_CYCLES - 1);

  cft_state_t       cur;
  cft_state_t       next_cur;
  logic             tick;
  logic [4:0]       det;
  logic [4:0]       rel;
  logic [4:0][22:0] lim;
  logic [15:0]      recLim;
  logic [4:0]       setEvt;
  logic [4:0]       clrEvt;
  cft_cfg_t         capCfg;

  // comparator levels are read only after the second sync stage
  assign det = cur.sync2.detect;
  assign rel[F_OVC] = cur.sync2.cellBelowOvRel &
                      cur.sync2.negAboveOccMin;
  assign rel[F_UVD] = cur.sync2.cellAboveUvRel;
  assign rel[F_OCD] = cur.sync2.batNegAbove1V;
  assign rel[F_OCC] = cur.sync2.negAboveOccMin;
  assign rel[F_SHORT] = cur.sync2.batNegAbove1V;

  // one tick per microsecond of oscillator time
  assign tick = (cur.presc == TICK_LAST);

  assign lim[F_OVC] = OVC_LIM[cur.cfg.ovcDly];
  assign lim[F_UVD] = UVD_LIM[cur.cfg.uvdDly];
  assign lim[F_OCD] = OCD_LIM[cur.cfg.ocdDly];
  assign lim[F_OCC] = OCC_LIM[cur.cfg.occDly];
  assign lim[F_SHORT] = SHORT_LIM;

  // a zero recovery setting acts as one tick; either value expires on the first tick
  assign recLim = (cur.recLimit == 16'h0000) ? 16'h0001 : cur.recLimit;

  assign clrEvt = (regWe && regAddr == REG_EVENT) ? regWdata[4:0]
                                                  : 5'h00;

  // out-of-range codes saturate rather than wrap to a low reference
  always_comb begin
    capCfg = cfgIn;
    if (cfgIn.uvdThr > UVD_THR_MAX) begin
      capCfg.uvdThr = UVD_THR_MAX;
    end
    if (cfgIn.ocdThr > OCD_THR_MAX) begin
      capCfg.ocdThr = OCD_THR_MAX;
    end
    if (cfgIn.occThr > OCC_THR_MAX) begin
      capCfg.occThr = OCC_THR_MAX;
    end
  end

  always_comb begin
    next_cur = cur;
    setEvt = 5'h00;
    next_cur.sync1 = cmpIn;
    next_cur.sync2 = cur.sync1;
    next_cur.presc = tick ? 8'h00 : cur.presc + 8'h01;
    // captured once just after reset; the pins may move later
    if (!cur.cfgDone) begin
      next_cur.cfg = capCfg;
      next_cur.cfgDone = 1'b1;
    end
    for (int i = 0; i < NUM_FAULTS; i++) begin
      if (!cur.latched[i]) begin
        next_cur.rec[i] = 16'h0000;
        if (!det[i]) begin
          next_cur.qual[i] = 23'h000000;
        end else if (tick && cur.cfgDone) begin
          if (cur.qual[i] + 23'h000001 >= lim[i]) begin
            next_cur.latched[i] = 1'b1;
            next_cur.qual[i] = 23'h000000;
          end else begin
            next_cur.qual[i] = cur.qual[i] + 23'h000001;
          end
        end
      end else begin
        next_cur.qual[i] = 23'h000000;
        // recurrence or a lost release restarts the recovery wait
        if (det[i] || !rel[i]) begin
          next_cur.rec[i] = 16'h0000;
        end else if (tick) begin
          if (cur.rec[i] + 16'h0001 >= recLim) begin
            next_cur.latched[i] = 1'b0;
            next_cur.rec[i] = 16'h0000;
          end else begin
            next_cur.rec[i] = cur.rec[i] + 16'h0001;
          end
        end
      end
    end
    setEvt = next_cur.latched & ~cur.latched;
    // a new fault in the clearing cycle keeps its flag
    next_cur.events = (cur.events & ~clrEvt) | setEvt;
    // high drives the FET on; both on with no fault present
    next_cur.chargeGate = ~(next_cur.latched[F_OVC] |
                            next_cur.latched[F_OCC]);
    next_cur.dischargeGate = ~(next_cur.latched[F_UVD] |
                               next_cur.latched[F_OCD] |
                               next_cur.latched[F_SHORT]);
    if (regWe) begin
      if (regAddr == REG_RECOVERY) begin
        next_cur.recLimit = regWdata;
      end
    end
    next_cur.rdata = 16'h0000;
    if (regRe) begin
      if (regAddr == REG_STATUS) begin
        next_cur.rdata = {4'h0, det, cur.dischargeGate,
                          cur.chargeGate, cur.latched};
      end else if (regAddr == REG_RECOVERY) begin
        next_cur.rdata = cur.recLimit;
      end else if (regAddr == REG_CONFIG) begin
        next_cur.rdata = {8'h00, cur.cfg.ovcDly, cur.cfg.uvdDly,
                          cur.cfg.ocdDly, cur.cfg.occDly};
      end else if (regAddr == REG_EVENT) begin
        next_cur.rdata = {11'h000, cur.events};
      end else begin
        next_cur.rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cur <= STATE_RST;
    end else begin
      cur <= next_cur;
    end
  end

  assign regRdata = cur.rdata;
  assign chargeGateOut = cur.chargeGate;
  assign dischargeGateOut = cur.dischargeGate;
  // captured threshold codes, saturated at their maxima, go to the comparator references
  assign refSel = cur.cfg;

  a_charge_gate_map: assert property (@(posedge mclk) disable iff (sys_rst)
    chargeGateOut == !(cur.latched[F_OVC] | cur.latched[F_OCC]))
    else $error("charge gate does not follow its faults");

  a_discharge_gate_map: assert property (@(posedge mclk)
    disable iff (sys_rst)
    dischargeGateOut == !(cur.latched[F_UVD] | cur.latched[F_OCD] |
                          cur.latched[F_SHORT]))
    else $error("discharge gate does not follow its faults");

  a_gates_on_idle: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (cur.latched == 5'h00) |-> (chargeGateOut && dischargeGateOut))
    else $error("gate off with no fault latched");

  a_qual_clear_early: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (!det[F_OCD] && !cur.latched[F_OCD]) |=>
      (cur.qual[F_OCD] == 23'h000000) && !cur.latched[F_OCD])
    else $error("qualification count kept after comparator clear");

  a_ovc_latch_cause: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $rose(cur.latched[F_OVC]) |->
      $past(det[F_OVC]) && $past(tick) &&
      ($past(cur.qual[F_OVC]) + 23'h000001 >= $past(lim[F_OVC])))
    else $error("overcharge latched before its delay");

  a_short_latch_time: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $rose(cur.latched[F_SHORT]) |->
      ($past(cur.qual[F_SHORT]) + 23'h000001 == SHORT_LIM) &&
      $past(det[F_SHORT]))
    else $error("short latched at the wrong count");

  a_occ_latch_cause: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $rose(cur.latched[F_OCC]) |->
      $past(det[F_OCC]) && $past(tick) &&
      ($past(cur.qual[F_OCC]) + 23'h000001 >= $past(lim[F_OCC])))
    else $error("charge overcurrent latched before its delay");

  a_recovery_restart: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (cur.latched[F_UVD] && det[F_UVD]) |=>
      (cur.rec[F_UVD] == 16'h0000) && cur.latched[F_UVD])
    else $error("recovery timer ran while the fault recurred");

  a_ovc_release_cause: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $fell(cur.latched[F_OVC]) |->
      $past(rel[F_OVC]) && !$past(det[F_OVC]) &&
      ($past(cur.rec[F_OVC]) + 16'h0001 >= $past(recLim)))
    else $error("overcharge released without its release condition");

  a_ocd_release_cause: assert property (@(posedge mclk)
    disable iff (sys_rst)
    $fell(cur.latched[F_OCD]) |->
      $past(cur.sync2.batNegAbove1V) && $past(tick))
    else $error("discharge overcurrent released without 1 V margin");

  a_cfg_frozen: assert property (@(posedge mclk)
    disable iff (sys_rst)
    (cur.cfgDone && $past(cur.cfgDone)) |-> $stable(refSel))
    else $error("factory selection changed during operation");

  a_thr_in_range: assert property (@(posedge mclk)
    disable iff (sys_rst)
    cur.cfgDone |-> (refSel.ocdThr <= OCD_THR_MAX) &&
                    (refSel.occThr <= OCC_THR_MAX) &&
                    (refSel.uvdThr <= UVD_THR_MAX))
    else $error("threshold code outside its range");

  a_event_set_wins: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(cur.latched[F_OVC]) |-> cur.events[F_OVC])
    else $error("fault event flag lost");

  a_read_one_cycle: assert property (@(posedge mclk) disable iff (sys_rst)
    !$past(regRe) |-> (regRdata == 16'h0000))
    else $error("read data outside the answer cycle");

endmodule

//--- cft_fet_model.sv
`timescale 1ns/1ps
module cft_fet_model (
  input  wire logic chargeGate,
  input  wire logic dischargeGate,
  output logic      chargeOn,
  output logic      dischargeOn
);
  // an undriven or unknown gate leaves the fet off, as a real fet would
  assign chargeOn    = (chargeGate === 1'b1);
  assign dischargeOn = (dischargeGate === 1'b1);
endmodule

//--- cft_pkg.sv
// What this block does
// - overcharge delay: 0.25, 1.0, 1.25, 4.5 s
// - overdischarge delay: 20, 96, 125, 144 ms
// - discharge overcurrent delay: 8, 16, 20, 48 ms
// - charge overcurrent delay: 4, 6, 8, 16 ms
// - short delay fixed at 250 us
// - overcharge threshold code, 3.85-4.6 V, 50 mV
// - overdischarge threshold code, 2.0-2.8 V, 50 mV
// - discharge overcurrent code, 90-200 mV, 5 mV
// - charge overcurrent code, 45-155 mV, 5 mV
// - short threshold: two-bit code, 300-600 mV
// - overcharge releases: hysteresis and negative-terminal condition
// - discharge overcurrent releases when difference above 1 V
// - charge overcurrent releases at minimum release level
// - short releases when difference reaches 1 V
// - gate output high means FET on
// - overcharge expiry drops charge gate; release raises it
// - overdischarge drops discharge gate; release raises it
// - discharge overcurrent expiry drops discharge gate
// - short trip starts timer; expiry drops discharge gate
// - charge overcurrent expiry drops charge gate
// - delays counted on oscillator ticks from onset
// - recovery timer restarts if fault recurs
// - no fault: both gates on
package cft_pkg;
  localparam int NUM_FAULTS = 5;
  localparam int F_OVC = 0;
  localparam int F_UVD = 1;
  localparam int F_OCD = 2;
  localparam int F_OCC = 3;
  localparam int F_SHORT = 4;
  localparam int CLK_MHZ = 125;
  localparam int TICK_US = 1;
  localparam int OVC_DLY_US [4] = '{250000, 1000000, 1250000, 4500000};
  localparam int UVD_DLY_US [4] = '{20000, 96000, 125000, 144000};
  localparam int OCD_DLY_US [4] = '{8000, 16000, 20000, 48000};
  localparam int OCC_DLY_US [4] = '{4000, 6000, 8000, 16000};
  localparam int SHORT_DLY_US = 250;
  localparam logic [4:0] UVD_THR_MAX = 5'h10;
  localparam logic [4:0] OCD_THR_MAX = 5'h16;
  localparam logic [4:0] OCC_THR_MAX = 5'h16;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_RECOVERY = 4'h1;
  localparam logic [3:0] REG_CONFIG = 4'h2;
  localparam logic [3:0] REG_EVENT = 4'h3;
  localparam logic [15:0] RECOVERY_RST = 16'h0010;
  typedef struct packed {
    logic [4:0] detect;
    logic       cellBelowOvRel;
    logic       negAboveOccMin;
    logic       cellAboveUvRel;
    logic       batNegAbove1V;
  } cft_cmp_t;
  typedef struct packed {
    logic [1:0] ovcDly;
    logic [1:0] uvdDly;
    logic [1:0] ocdDly;
    logic [1:0] occDly;
    logic [3:0] ovcThr;
    logic [4:0] uvdThr;
    logic [4:0] ocdThr;
    logic [4:0] occThr;
    logic [1:0] shortThr;
  } cft_cfg_t;
  typedef struct packed {
    cft_cmp_t         sync1;
    cft_cmp_t         sync2;
    logic [7:0]       presc;
    logic [4:0][22:0] qual;
    logic [4:0][15:0] rec;
    logic [4:0]       latched;
    logic [4:0]       events;
    logic             chargeGate;
    logic             dischargeGate;
    cft_cfg_t         cfg;
    logic             cfgDone;
    logic [15:0]      recLimit;
    logic [15:0]      rdata;
  } cft_state_t;
  localparam cft_state_t STATE_RST = '{chargeGate: 1'b1,
    dischargeGate: 1'b1, recLimit: RECOVERY_RST, default: '0};
endpackage
